// *** core/atacfg_pkg.sv ***
// constants and types shared by the drive init and transfer mode configuration block
package atacfg_pkg;

  // configuration byte addresses
  localparam logic [7:0] ADDR_RESET_METHOD = 8'h05;
  localparam logic [7:0] ADDR_UDMA_SEL = 8'h06;
  localparam logic [7:0] ADDR_DMA_PIO_SEL = 8'h07;

  // reset values (variable contents of the configuration store)
  localparam logic [7:0] RST_RESET_METHOD = 8'h07;
  localparam logic [7:0] RST_UDMA_SEL = 8'hd4;
  localparam logic [7:0] RST_DMA_PIO_SEL = 8'h07;

  // field positions
  localparam int BIT_SKIP_PIN_RESET = 0;
  localparam int BIT_SOFT_RESET_EN = 1;
  localparam int BIT_ATA_UDMA_EN = 7;
  localparam int BIT_ATAPI_UDMA_EN = 6;
  localparam int BIT_UDMA_MODE_LO = 2;
  localparam int BIT_UDMA_MODE_HI = 4;
  localparam int BIT_MWDMA_EN = 2;
  localparam int BIT_PIO_MODE3_EN = 0;
  localparam int BIT_PIO_MODE4_EN = 1;

  // timing of the hardware reset pulse on the drive pin
  localparam int CLK_FREQ_KHZ = 10000;
  localparam int HW_RESET_PULSE_US = 25;
  localparam int HW_RESET_CYCLES = (HW_RESET_PULSE_US * CLK_FREQ_KHZ + 999) / 1000;
  localparam int HW_RESET_CNT_W = 12;

  // transfer method chosen for the attached drive
  typedef enum logic [1:0] {
    ATACFG_XFER_PIO = 2'h0,
    ATACFG_XFER_MWDMA = 2'h1,
    ATACFG_XFER_UDMA = 2'h2
  } atacfg_xfer_t;

  // capabilities reported by the drive's identify data
  typedef struct packed {
    logic is_atapi;
    logic [2:0] udma_sup;  // [2]=mode 4, [1]=mode 3, [0]=mode 2
    logic mwdma_sup;
    logic [1:0] pio_sup;   // [1]=mode 4, [0]=mode 3
  } atacfg_caps_t;

  // negotiated transfer setting
  typedef struct packed {
    atacfg_xfer_t method;
    logic [2:0] mode;
  } atacfg_sel_t;

  localparam logic [2:0] PIO_MODE_BASE = 3'h0;
  localparam logic [2:0] MODE_HI = 3'h4;
  localparam logic [2:0] MODE_MID = 3'h3;
  localparam logic [2:0] MODE_LO = 3'h2;
  localparam logic [2:0] MWDMA_MODE = 3'h2;

endpackage

// *** core/atacfg_mode_pick.sv ***
// combinational choice of transfer method and mode from configuration and drive caps
`timescale 1ns/1ps
module atacfg_mode_pick
  import atacfg_pkg::*;
(
  // configuration bytes
  input wire logic [7:0] udma_sel,
  input wire logic [7:0] dma_pio_sel,
  // drive capabilities
  input wire atacfg_caps_t caps,
  // choice
  output atacfg_sel_t pick
);

  // highest of three enables; bit 2 weighs most
  function automatic logic [1:0] top3(input logic [2:0] v);
    if (v[2]) begin
      top3 = 2'h3;
    end else if (v[1]) begin
      top3 = 2'h2;
    end else if (v[0]) begin
      top3 = 2'h1;
    end else begin
      top3 = 2'h0;
    end
  endfunction

  logic udma_allowed;
  logic [2:0] udma_ok;
  logic [1:0] udma_top;
  logic [1:0] pio_top;

  // reserved bits 5,1,0 are ignored: only modes 2..4 exist
  assign udma_allowed = caps.is_atapi ? udma_sel[BIT_ATAPI_UDMA_EN]
                                      : udma_sel[BIT_ATA_UDMA_EN]; // R4 R5
  assign udma_ok = udma_sel[BIT_UDMA_MODE_HI:BIT_UDMA_MODE_LO] & caps.udma_sup; // R6
  assign udma_top = top3(udma_ok); // R6
  // mode 0 sits below the two enables and is always permitted
  assign pio_top = top3({dma_pio_sel[BIT_PIO_MODE4_EN], dma_pio_sel[BIT_PIO_MODE3_EN], 1'b1}
                        & {caps.pio_sup, 1'b1}); // R9 R10

  always_comb begin
    pick.method = ATACFG_XFER_PIO;
    pick.mode = PIO_MODE_BASE;
    if (udma_allowed && (udma_top != 2'h0)) begin // R11
      pick.method = ATACFG_XFER_UDMA;
      case (udma_top)
        2'h3: pick.mode = MODE_HI;
        2'h2: pick.mode = MODE_MID;
        default: pick.mode = MODE_LO;
      endcase
    end else if (dma_pio_sel[BIT_MWDMA_EN] && caps.mwdma_sup) begin // R8 R11
      pick.method = ATACFG_XFER_MWDMA;
      pick.mode = MWDMA_MODE;
    end else begin
      case (pio_top) // R9 R10
        2'h3: pick.mode = MODE_HI;
        2'h2: pick.mode = MODE_MID;
        default: pick.mode = PIO_MODE_BASE;
      endcase
    end
  end

endmodule

// *** core/atacfg_top.sv ***
// drive init sequencing and transfer mode configuration from stored config bytes
//
// What this block does
// R1: soft-reset bit set means issue drive software reset during init; clear skips it.
// R2: configuration must never clear soft-reset while setting skip-pin-reset. The block does not check this and accepts such a write.
// R3: skip-pin-reset set suppresses reset pin except after chip reset; clear always pulses.
// R4: Udma_mode_select permits Ultra DMA with ATA drives at highest shared mode.
// R5: ATAPI UDMA enable permits Ultra DMA with ATAPI drives.
// R6: UDMA bits 4,3,2 enable modes 4,3,2; use highest one drive supports.
// R7: configuration keeps reserved UDMA bits 5,1,0 and mode byte bits 7:3 zero.
// R8: multiword DMA enable plus drive support selects multiword DMA; otherwise never.
// R9: PIO bits enable mode 4 and mode 3 independently; use highest supported.
// R10: PIO mode 0 is always allowed and is the fallback.
// R11: prefer Ultra DMA, then multiword DMA, then highest permitted PIO mode.
`timescale 1ns/1ps
module atacfg_top
  import atacfg_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // configuration byte port, loaded from the configuration store
  input wire logic cfg_wr_en,
  input wire logic cfg_rd_en,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wr_data,
  output logic [7:0] cfg_rd_data,
  output logic cfg_rd_valid,
  // drive initialization control
  input wire logic init_req,
  input wire atacfg_caps_t drive_caps,
  input wire logic srst_done,
  output logic srst_req,
  output logic init_busy,
  output logic init_done,
  // drive pin
  output logic drive_hw_reset_pin_n,
  // negotiated transfer setting
  output atacfg_sel_t xfer_sel
);

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_HWRST = 5'h02,
    ST_SRST = 5'h04,
    ST_SRST_WAIT = 5'h08,
    ST_SELECT = 5'h10
  } atacfg_state_t;

  localparam logic [HW_RESET_CNT_W-1:0] HW_RESET_LAST =
    HW_RESET_CNT_W'(HW_RESET_CYCLES - 1);

  atacfg_state_t state_q;
  atacfg_state_t state_d;
  logic [7:0] reset_method_q;
  logic [7:0] udma_sel_q;
  logic [7:0] dma_pio_sel_q;
  logic chip_reset_pending_q;
  logic [HW_RESET_CNT_W-1:0] pulse_cnt_q;
  atacfg_sel_t pick;
  logic want_pin_reset;
  logic [2:0] addr_hit;
  logic soft_reset_en;
  logic skip_pin_reset;

  // positions in the one-hot byte select
  localparam int HIT_RESET_METHOD = 0;
  localparam int HIT_UDMA_SEL = 1;
  localparam int HIT_DMA_PIO_SEL = 2;

  // which configuration byte an address selects; unmapped addresses select none
  function automatic logic [2:0] cfg_hit(input logic [7:0] addr);
    cfg_hit = 3'h0;
    if (addr == ADDR_RESET_METHOD) begin
      cfg_hit[HIT_RESET_METHOD] = 1'b1;
    end else if (addr == ADDR_UDMA_SEL) begin
      cfg_hit[HIT_UDMA_SEL] = 1'b1;
    end else if (addr == ADDR_DMA_PIO_SEL) begin
      cfg_hit[HIT_DMA_PIO_SEL] = 1'b1;
    end
  endfunction

  // write and read share one decode so the two maps cannot drift apart
  assign addr_hit = cfg_hit(cfg_addr);

  // only the two low bits act; the rest of the byte is stored for read back
  assign soft_reset_en = reset_method_q[BIT_SOFT_RESET_EN];
  assign skip_pin_reset = reset_method_q[BIT_SKIP_PIN_RESET];

  // configuration bytes; reserved bits are kept as written and ignored by the logic
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reset_method_q <= RST_RESET_METHOD;
      udma_sel_q <= RST_UDMA_SEL;
      dma_pio_sel_q <= RST_DMA_PIO_SEL;
    end else if (cfg_wr_en) begin
      if (addr_hit[HIT_RESET_METHOD]) begin
        reset_method_q <= cfg_wr_data;
      end else if (addr_hit[HIT_UDMA_SEL]) begin
        udma_sel_q <= cfg_wr_data;
      end else if (addr_hit[HIT_DMA_PIO_SEL]) begin
        dma_pio_sel_q <= cfg_wr_data;
      end
    end
  end

  // read back; unmapped addresses answer zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_rd_data <= 8'h00;
      cfg_rd_valid <= 1'b0;
    end else begin
      cfg_rd_valid <= cfg_rd_en;
      if (cfg_rd_en) begin
        if (addr_hit[HIT_RESET_METHOD]) begin
          cfg_rd_data <= reset_method_q;
        end else if (addr_hit[HIT_UDMA_SEL]) begin
          cfg_rd_data <= udma_sel_q;
        end else if (addr_hit[HIT_DMA_PIO_SEL]) begin
          cfg_rd_data <= dma_pio_sel_q;
        end else begin
          cfg_rd_data <= 8'h00;
        end
      end
    end
  end

  atacfg_mode_pick u_pick (
    .udma_sel(udma_sel_q),
    .dma_pio_sel(dma_pio_sel_q),
    .caps(drive_caps),
    .pick(pick)
  );

  // the first init after chip reset always pulses the pin, whatever skip says
  assign want_pin_reset = chip_reset_pending_q
                          || !skip_pin_reset; // R3

  // a bad config with both methods off leaves every init after the first following chip reset with no drive reset; not guarded here
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (init_req) begin
          if (want_pin_reset) begin // R3
            state_d = ST_HWRST;
          end else if (soft_reset_en) begin // R1 R2
            state_d = ST_SRST;
          end else begin
            state_d = ST_SELECT;
          end
        end
      end
      ST_HWRST: begin
        if (pulse_cnt_q == HW_RESET_LAST) begin
          state_d = soft_reset_en ? ST_SRST : ST_SELECT; // R1
        end
      end
      ST_SRST: state_d = ST_SRST_WAIT;
      // no timeout: a drive that never finishes its soft reset keeps the block busy
      ST_SRST_WAIT: begin
        if (srst_done) begin
          state_d = ST_SELECT;
        end
      end
      ST_SELECT: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // pulse width counter and pin; pin is held low through chip reset itself
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pulse_cnt_q <= '0;
      drive_hw_reset_pin_n <= 1'b0;
    end else begin
      drive_hw_reset_pin_n <= (state_d != ST_HWRST); // R3
      if (state_q == ST_HWRST) begin
        pulse_cnt_q <= pulse_cnt_q + 1'b1;
      end else begin
        pulse_cnt_q <= '0;
      end
    end
  end

  // set by chip reset and cleared in the first cycle of the pin pulse, so skip spares later inits only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      chip_reset_pending_q <= 1'b1;
    end else if (state_q == ST_HWRST) begin
      chip_reset_pending_q <= 1'b0; // R3
    end
  end

  // handshake outputs to the ATA engine
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      srst_req <= 1'b0;
      init_done <= 1'b0;
    end else begin
      srst_req <= (state_d == ST_SRST); // R1
      init_done <= (state_q == ST_SELECT);
    end
  end

  // combinational: busy drops in the very cycle init_done pulses
  assign init_busy = (state_q != ST_IDLE);

  // the setting is latched once per init so it cannot shift under a running transfer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      xfer_sel <= '{method: ATACFG_XFER_PIO, mode: PIO_MODE_BASE}; // R10
    end else if (state_q == ST_SELECT) begin
      xfer_sel <= pick; // R11
    end
  end

endmodule

// *** bench/atacfg_assertions.sv ***
// checker on the top ports of the drive init block
`timescale 1ns/1ps
module atacfg_checker
  import atacfg_pkg::*;
(
  // watched ports
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cfg_rd_en,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_rd_data,
  input wire logic cfg_rd_valid,
  input wire logic init_req,
  input wire logic srst_req,
  input wire logic init_busy,
  input wire logic init_done,
  input wire logic drive_hw_reset_pin_n,
  input wire atacfg_sel_t xfer_sel
);
  logic [8:0] low_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // length of the current low stretch of the drive pin
  always_ff @(posedge sys_clk) begin
    if (rst || drive_hw_reset_pin_n) begin
      low_q <= 9'h000;
    end else begin
      low_q <= low_q + 9'h001;
    end
  end
  a_rd_answer: assert property (cfg_rd_en |=> cfg_rd_valid) else $error("no read answer");
  a_rd_unmapped: assert property (cfg_rd_en && cfg_addr > 8'h07 |=> cfg_rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_pin_width: assert property ($rose(drive_hw_reset_pin_n) && low_q > 9'h001 |->
    low_q == HW_RESET_CYCLES) else $error("pin pulse width");
  a_pin_bound: assert property (low_q <= HW_RESET_CYCLES) else $error("pin low too long");
  a_pin_in_init: assert property ($fell(drive_hw_reset_pin_n) |-> init_busy)
    else $error("pin low outside init");
  a_srst_pulse: assert property (srst_req |=> !srst_req && init_busy)
    else $error("srst pulse");
  a_srst_after_pin: assert property (srst_req |-> drive_hw_reset_pin_n && init_busy)
    else $error("srst during pin reset");
  a_init_start: assert property (init_req && !init_busy |=> init_busy) else $error("init not taken");
  a_done_pulse: assert property (init_done |-> !init_busy ##1 !init_done) else $error("done pulse");
  a_sel_hold: assert property (!init_done |-> $stable(xfer_sel))
    else $error("selection changed without done");
endmodule
bind atacfg_top atacfg_checker i_chk (.sys_clk, .rst, .cfg_rd_en, .cfg_addr, .cfg_rd_data,
  .cfg_rd_valid, .init_req, .srst_req, .init_busy, .init_done, .drive_hw_reset_pin_n, .xfer_sel);

// *** bench/atacfg_drive_model.sv ***
// drive side: answers a software reset request after a chosen delay
`timescale 1ns/1ps
module atacfg_drive_model (
  // clock
  input wire logic sys_clk,
  // reset handshake
  input wire logic srst_req,
  input wire logic [3:0] lat,
  output logic srst_done
);
  int cnt = -1;
  initial srst_done = 1'b0;
  // a pulse, so a stale level never fakes completion
  always @(posedge sys_clk) begin
    srst_done <= 1'b0;
    if (srst_req) begin
      cnt = int'(lat);
    end else if (cnt > 0) begin
      cnt = cnt - 1;
    end else if (cnt == 0) begin
      srst_done <= 1'b1;
      cnt = -1;
    end
  end
endmodule

// *** bench/tb_ata_init_and_transfer_mode_config.sv ***
// self-checking bench for the drive init and mode configuration block
`timescale 1ns/1ps
module tb_ata_init_and_transfer_mode_config;
  import atacfg_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, cfg_wr_en = 1'b0, cfg_rd_en = 1'b0, init_req = 1'b0;
  logic srst_done, srst_req, cfg_rd_valid, init_busy, init_done, drive_hw_reset_pin_n;
  logic [7:0] cfg_addr = 8'h00, cfg_wr_data = 8'h00, cfg_rd_data, u = 8'hd4, d = 8'h07;
  logic [3:0] lat = 4'h0;
  atacfg_caps_t drive_caps = '1;
  atacfg_sel_t xfer_sel;
  int err_total = 0, checks = 0, low_cnt, srst_cnt, done_cnt;

  atacfg_top i_dut (.sys_clk, .rst, .cfg_wr_en, .cfg_rd_en, .cfg_addr, .cfg_wr_data,
    .cfg_rd_data, .cfg_rd_valid, .init_req, .drive_caps, .srst_done, .srst_req, .init_busy,
    .init_done, .drive_hw_reset_pin_n, .xfer_sel);
  atacfg_drive_model i_drv (.sys_clk, .srst_req, .lat, .srst_done);

  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    low_cnt += int'(!rst && !drive_hw_reset_pin_n);
    srst_cnt += int'(srst_req);
    done_cnt += int'(init_done);
  end

  task automatic conclude();
    $display("errors %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic cmp_val(logic [8:0] got, logic [8:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_sel(atacfg_sel_t got, atacfg_sel_t exp);
    cmp_val({4'h0, got}, {4'h0, exp});
  endtask
  task automatic cfg(logic we, logic [7:0] a, logic [7:0] v);
    @(negedge sys_clk);
    cfg_wr_en = we;
    cfg_rd_en = !we;
    cfg_addr = a;
    cfg_wr_data = v;
    @(negedge sys_clk);
    cfg_wr_en = 1'b0;
    cfg_rd_en = 1'b0;
    if (!we) begin
      cmp_val({8'h00, cfg_rd_valid}, 9'h001);
      cmp_val({1'b0, cfg_rd_data}, {1'b0, v});
    end
  endtask
  function automatic atacfg_sel_t model(int u, int d, atacfg_caps_t c);
    int m;
    m = (u >> 2) & int'(c.udma_sup);
    if ((((c.is_atapi ? u >> 6 : u >> 7) & 1) != 0) && m != 0) begin
      return '{ATACFG_XFER_UDMA, m[2] ? 3'h4 : m[1] ? 3'h3 : 3'h2};
    end else if (((d >> 2) & int'(c.mwdma_sup)) != 0) begin
      return '{ATACFG_XFER_MWDMA, 3'h2};
    end
    m = d & int'(c.pio_sup);
    return '{ATACFG_XFER_PIO, m[1] ? 3'h4 : m[0] ? 3'h3 : 3'h0};
  endfunction
  // a second request while busy must be ignored
  task automatic run_init(int pin_exp, int srst_exp);
    int n;
    @(negedge sys_clk);
    low_cnt = 0;
    srst_cnt = 0;
    done_cnt = 0;
    init_req = 1'b1;
    repeat (2) @(negedge sys_clk);
    init_req = 1'b0;
    for (n = 0; n < 2000 && done_cnt == 0; n++) @(negedge sys_clk);
    if (n == 2000) begin
      err_total++;
      conclude();
    end
    repeat (2) @(negedge sys_clk);
    cmp_val(9'(done_cnt), 9'h001);
    cmp_val(9'(low_cnt), 9'(pin_exp));
    cmp_val(9'(srst_cnt), 9'(srst_exp));
    cmp_val({8'h00, init_busy}, 9'h000);
    cmp_sel(xfer_sel, model(int'(u), int'(d), drive_caps));
  endtask

  initial begin
    void'($urandom(32'h987ceb76));
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    cfg(1'b0, 8'h05, 8'h07);
    cfg(1'b0, 8'h06, 8'hd4);
    cfg(1'b0, 8'h07, 8'h07);
    cfg(1'b1, 8'h20, 8'hff);
    cfg(1'b0, 8'h20, 8'h00);
    run_init(250, 1);
    run_init(0, 1);
    cfg(1'b1, 8'h05, 8'h02);
    run_init(250, 1);
    cfg(1'b1, 8'h05, 8'h00);
    run_init(250, 0);
    cfg(1'b1, 8'h05, 8'h03);
    repeat (60) begin
      u = 8'($urandom) & 8'hdc;
      d = 8'($urandom) & 8'h07;
      drive_caps = 7'($urandom);
      lat = 4'($urandom);
      cfg(1'b1, 8'h06, u);
      cfg(1'b1, 8'h07, d);
      cfg(1'b0, 8'h06, u);
      run_init(0, 1);
    end
    // a reset in mid-run restores the bytes and makes the next init pulse the pin again
    @(negedge sys_clk);
    rst = 1'b1;
    repeat (3) @(negedge sys_clk);
    cmp_val({8'h00, drive_hw_reset_pin_n}, 9'h000);
    rst = 1'b0;
    u = 8'hd4;
    d = 8'h07;
    cmp_sel(xfer_sel, '{ATACFG_XFER_PIO, 3'h0});
    cfg(1'b0, 8'h05, 8'h07);
    cfg(1'b0, 8'h06, 8'hd4);
    cfg(1'b0, 8'h07, 8'h07);
    run_init(250, 1);
    run_init(0, 1);
    conclude();
  end
endmodule
